/* src/mag_extremes_pkg.sv */
// Shared constants, carriers and state codes for the magnetic
// extremes, degauss scheduling and burst-wrap control block.
// Assumes one 40 MHz clock domain and a 32-bit APB register bus.
`default_nettype none

package mag_extremes_pkg;

	// ***************************************************************
	// Register byte addresses
	// ***************************************************************
	localparam logic [11:0] ADDR_MAG_CONTROL_TWO = 12'h05C;
	localparam logic [11:0] ADDR_MAG_CONTROL_ONE = 12'h060;
	localparam logic [11:0] ADDR_SYSTEM_CONTROL_ONE = 12'h064;
	localparam logic [11:0] ADDR_STATUS = 12'h068;
	localparam logic [11:0] ADDR_EXTREMES_BASE = 12'h070;
	localparam logic [11:0] ADDR_OFFSET_BASE = 12'h080;

	// ***************************************************************
	// Reset values
	// ***************************************************************
	localparam logic [7:0] RST_MAG_CONTROL_TWO = 8'h00;
	localparam logic [7:0] RST_MAG_CONTROL_ONE = 8'h00;
	localparam logic [1:0] RST_SYSTEM_CONTROL_ONE = 2'h0;
	localparam logic [15:0] EXT_MIN_CLEAR = 16'h7FFF;
	localparam logic [15:0] EXT_MAX_CLEAR = 16'h8000;

	// ***************************************************************
	// Field positions
	// ***************************************************************
	// mag_control_two
	localparam int HYB_WRAP_BIT = 5;
	localparam int TRACK_DIS_BIT = 4;
	localparam int STOP_THS_BIT = 3;
	localparam int EXT_CLEAR_BIT = 2;
	localparam int DG_IVL_LSB = 0;
	// mag_control_one
	localparam int ACAL_BIT = 7;
	localparam int DG_ONESHOT_BIT = 6;
	localparam int SENSOR_SEL_LSB = 0;
	// system_control_one
	localparam int ACTIVE_BIT = 0;
	localparam int FAST_READ_BIT = 1;

	// ***************************************************************
	// Encodings and counts
	// ***************************************************************
	localparam logic [1:0] DG_EVERY_ODR = 2'h0;
	localparam logic [1:0] DG_EVERY_16 = 2'h1;
	localparam logic [1:0] DG_EVERY_512 = 2'h2;
	localparam logic [1:0] SEL_HYBRID = 2'h3;
	localparam int DG_COUNT_16 = 16;
	localparam int DG_COUNT_512 = 512;
	localparam logic [7:0] BURST_ACC_Z_LOW = 8'h06;
	localparam logic [7:0] BURST_ACC_Z_HIGH = 8'h05;
	localparam logic [7:0] BURST_MAG_X_HIGH = 8'h33;

	// Three magnetic axes in one carrier
	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] z;
	} mag_sample_s;

	typedef enum logic {
		CLR_IDLE = 1'b0,
		CLR_LOAD = 1'b1
	} clr_state_e;

	typedef enum logic {
		DG_IDLE = 1'b0,
		DG_BUSY = 1'b1
	} dg_state_e;

endpackage : mag_extremes_pkg

`default_nettype wire

/* src/mag_axis_extremes.sv */
// One axis of min/max tracking and hard-iron offset computation.
// Assumes update, clear and calibrate are single-cycle strobes.
`default_nettype none

module mag_axis_extremes (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clear,
	input wire logic update,
	input wire logic calibrate,
	input wire logic [15:0] sample,
	output logic [15:0] max_val,
	output logic [15:0] min_val,
	output logic [15:0] offset_val
);

	// ***************************************************************
	// State
	// ***************************************************************
	typedef struct packed {
		logic [15:0] max_v;
		logic [15:0] min_v;
		logic [15:0] off_v;
	} axis_state_s;

	axis_state_s s_r; // Registered axis state
	axis_state_s s_nxt; // Next axis state
	logic [16:0] sum; // Sign-extended max plus min

	// Compare and load; clear beats update
	always_comb begin
		s_nxt = s_r;
		sum = {s_r.max_v[15], s_r.max_v} + {s_r.min_v[15], s_r.min_v};
		if (clear) begin
			s_nxt.min_v = mag_extremes_pkg::EXT_MIN_CLEAR;
			s_nxt.max_v = mag_extremes_pkg::EXT_MAX_CLEAR;
		end else if (update) begin
			// Signed compares: samples are two's complement
			if ($signed(sample) > $signed(s_r.max_v)) begin
				s_nxt.max_v = sample;
			end
			if ($signed(sample) < $signed(s_r.min_v)) begin
				s_nxt.min_v = sample;
			end
		end
		// Uses the stored extremes, so lags a fresh update by one cycle
		if (calibrate) begin
			s_nxt.off_v = sum[16:1];
		end
	end

	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '{max_v: mag_extremes_pkg::EXT_MAX_CLEAR,
				min_v: mag_extremes_pkg::EXT_MIN_CLEAR, off_v: 16'h0000};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign max_val = s_r.max_v;
	assign min_val = s_r.min_v;
	assign offset_val = s_r.off_v;

endmodule : mag_axis_extremes

`default_nettype wire

/* src/mag_burst_pointer.sv */
// Register pointer of the serial burst read, with hybrid wrap.
// Assumes load and advance strobes come from the serial logic.
`default_nettype none

module mag_burst_pointer (
	input wire logic clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [7:0] load_addr,
	input wire logic advance,
	input wire logic wrap_en,
	input wire logic fast_read,
	output logic [7:0] addr
);

	// ***************************************************************
	// State
	// ***************************************************************
	typedef struct packed {
		logic [7:0] ptr;
	} ptr_state_s;

	ptr_state_s s_r; // Registered pointer
	ptr_state_s s_nxt; // Next pointer
	logic [7:0] last_acc; // Last accelerometer byte before the jump

	// Load wins over advance; jump only at the last accel byte
	always_comb begin
		s_nxt = s_r;
		last_acc = fast_read ? mag_extremes_pkg::BURST_ACC_Z_HIGH :
			mag_extremes_pkg::BURST_ACC_Z_LOW;
		if (load) begin
			s_nxt.ptr = load_addr;
		end else if (advance) begin
			if (wrap_en && s_r.ptr == last_acc) begin
				s_nxt.ptr = mag_extremes_pkg::BURST_MAG_X_HIGH;
			end else begin
				s_nxt.ptr = s_r.ptr + 8'h01;
			end
		end
	end

	// Pointer register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '{ptr: 8'h00};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign addr = s_r.ptr;

endmodule : mag_burst_pointer

`default_nettype wire

/* src/mag_extremes_degauss_ctrl.sv */
// Magnetic control two: burst wrap, min/max tracking and degauss.
// Assumes all strobes come from logic on CLK; APB slave for software.
`default_nettype none

module mag_extremes_degauss_ctrl (
	input wire logic CLK,
	input wire logic RESETN,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Measurement side
	input wire logic ODR_START,
	input wire logic ODR_END,
	input wire logic MAG_SAMPLE_VALID,
	input wire mag_extremes_pkg::mag_sample_s MAG_SAMPLE,
	input wire logic THRESHOLD_EVENT,
	input wire logic DEGAUSS_DONE,
	output logic DEGAUSS_START,
	output mag_extremes_pkg::mag_sample_s MAG_OFFSET,
	// Serial burst pointer
	input wire logic BURST_LOAD,
	input wire logic [7:0] BURST_LOAD_ADDR,
	input wire logic BURST_ADVANCE,
	output logic [7:0] BURST_ADDR
);

	// ***************************************************************
	// State
	// ***************************************************************
	typedef struct packed {
		logic [7:0] ctrl_two; // mag_control_two
		logic [7:0] ctrl_one; // mag_control_one
		logic [1:0] sys_ctrl; // system_control_one
		logic thr_stop; // Tracking halted by threshold
		mag_extremes_pkg::mag_sample_s sample; // Latest sample
		logic [8:0] odr_cnt; // Magnetic ODR cycles seen
		logic hyb_phase; // Which half of hybrid pair
		logic active_d; // Previous active bit
		mag_extremes_pkg::clr_state_e clr_st; // Clear sequence
		mag_extremes_pkg::dg_state_e dg_st; // Degauss sequence
		logic dg_own_oneshot; // Running degauss was one-shot
		logic dg_start; // Degauss request pulse
		logic [15:0] dg_count; // Degauss pulses issued
		logic upd; // Extremes update strobe
		logic cal; // Offset load strobe
		logic clr; // Extremes clear strobe
		logic pready; // APB answer
		logic pslverr; // APB error
		logic [31:0] prdata; // APB read data
	} ctrl_state_s;

	ctrl_state_s s_r; // Registered state
	ctrl_state_s s_nxt; // Next state

	logic [15:0] ax_max [3]; // Per-axis maximum
	logic [15:0] ax_min [3]; // Per-axis minimum
	logic [15:0] ax_off [3]; // Per-axis offset
	logic [15:0] ax_smp [3]; // Per-axis sample

	// ***************************************************************
	// Address decode
	// ***************************************************************
	// Index 0..3 for control/status, 5..7 extremes, 8..10 offsets,
	// 15 for an unmapped address
	function automatic logic [3:0] reg_index(input logic [11:0] a);
		logic [3:0] idx;
		idx = 4'hF;
		case (a)
			mag_extremes_pkg::ADDR_MAG_CONTROL_TWO: idx = 4'h0;
			mag_extremes_pkg::ADDR_MAG_CONTROL_ONE: idx = 4'h1;
			mag_extremes_pkg::ADDR_SYSTEM_CONTROL_ONE: idx = 4'h2;
			mag_extremes_pkg::ADDR_STATUS: idx = 4'h3;
			mag_extremes_pkg::ADDR_EXTREMES_BASE: idx = 4'h5;
			mag_extremes_pkg::ADDR_EXTREMES_BASE + 12'h004: idx = 4'h6;
			mag_extremes_pkg::ADDR_EXTREMES_BASE + 12'h008: idx = 4'h7;
			mag_extremes_pkg::ADDR_OFFSET_BASE: idx = 4'h8;
			mag_extremes_pkg::ADDR_OFFSET_BASE + 12'h004: idx = 4'h9;
			mag_extremes_pkg::ADDR_OFFSET_BASE + 12'h008: idx = 4'hA;
			default: idx = 4'hF;
		endcase
		return idx;
	endfunction : reg_index

	// ***************************************************************
	// Per-axis extremes
	// ***************************************************************
	assign ax_smp[0] = s_r.sample.x;
	assign ax_smp[1] = s_r.sample.y;
	assign ax_smp[2] = s_r.sample.z;

	// Three identical trackers, one per axis
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_axis
			mag_axis_extremes u_axis (
				.clk(CLK),
				.resetn(RESETN),
				.clear(s_r.clr),
				.update(s_r.upd),
				.calibrate(s_r.cal),
				.sample(ax_smp[g]),
				.max_val(ax_max[g]),
				.min_val(ax_min[g]),
				.offset_val(ax_off[g])
			);
		end
	endgenerate

	// ***************************************************************
	// Burst pointer
	// ***************************************************************
	mag_burst_pointer u_burst (
		.clk(CLK),
		.resetn(RESETN),
		.load(BURST_LOAD),
		.load_addr(BURST_LOAD_ADDR),
		.advance(BURST_ADVANCE),
		.wrap_en(s_r.ctrl_two[mag_extremes_pkg::HYB_WRAP_BIT]),
		.fast_read(s_r.sys_ctrl[mag_extremes_pkg::FAST_READ_BIT]),
		.addr(BURST_ADDR)
	);

	// ***************************************************************
	// Next-state logic
	// ***************************************************************
	logic hybrid; // Both sensors active
	logic mag_start; // Start of a magnetic ODR cycle
	logic mag_end; // End of a magnetic ODR cycle
	logic track_en; // Min/max tracking running
	logic dg_due; // Periodic degauss falls due
	logic act_rise; // Standby to active transition
	logic access; // APB access phase
	logic [3:0] idx; // Decoded register
	logic [1:0] ivl; // Degauss interval field
	logic [31:0] rd; // Read mux

	always_comb begin
		s_nxt = s_r;
		s_nxt.dg_start = 1'b0;
		s_nxt.upd = 1'b0;
		s_nxt.cal = 1'b0;
		s_nxt.clr = 1'b0;
		// Hybrid: magnetic cycle is every second system cycle
		hybrid = s_r.ctrl_one[mag_extremes_pkg::SENSOR_SEL_LSB +: 2]
			== mag_extremes_pkg::SEL_HYBRID;
		mag_start = ODR_START && (!hybrid || !s_r.hyb_phase);
		mag_end = ODR_END && (!hybrid || s_r.hyb_phase);
		if (ODR_END && hybrid) begin
			s_nxt.hyb_phase = !s_r.hyb_phase;
		end else if (!hybrid) begin
			s_nxt.hyb_phase = 1'b0;
		end
		// Keep the newest sample of the cycle
		if (MAG_SAMPLE_VALID) begin
			s_nxt.sample = MAG_SAMPLE;
		end
		// Upper two bits are stored but steer nothing
		track_en = !s_r.ctrl_two[mag_extremes_pkg::TRACK_DIS_BIT]
			&& !s_r.thr_stop;
		s_nxt.upd = mag_end && track_en;
		s_nxt.cal = mag_end
			&& s_r.ctrl_one[mag_extremes_pkg::ACAL_BIT];

		// Extremes clear sequence: one load cycle, then self-clear
		case (s_r.clr_st)
			mag_extremes_pkg::CLR_IDLE: begin
				if (s_r.ctrl_two[mag_extremes_pkg::EXT_CLEAR_BIT]) begin
					s_nxt.clr = 1'b1;
					s_nxt.clr_st = mag_extremes_pkg::CLR_LOAD;
				end
			end
			mag_extremes_pkg::CLR_LOAD: begin
				s_nxt.ctrl_two[mag_extremes_pkg::EXT_CLEAR_BIT] = 1'b0;
				s_nxt.clr_st = mag_extremes_pkg::CLR_IDLE;
			end
			default: begin
				s_nxt.clr_st = mag_extremes_pkg::CLR_IDLE;
			end
		endcase

		// Periodic degauss schedule on magnetic cycle starts
		ivl = s_r.ctrl_two[mag_extremes_pkg::DG_IVL_LSB +: 2];
		case (ivl)
			mag_extremes_pkg::DG_EVERY_ODR: dg_due = mag_start;
			mag_extremes_pkg::DG_EVERY_16: dg_due = mag_start
				&& s_r.odr_cnt[3:0] == 4'(mag_extremes_pkg::DG_COUNT_16 - 1);
			mag_extremes_pkg::DG_EVERY_512: dg_due = mag_start
				&& s_r.odr_cnt == 9'(mag_extremes_pkg::DG_COUNT_512 - 1);
			default: dg_due = 1'b0;
		endcase
		if (mag_start) begin
			s_nxt.odr_cnt = s_r.odr_cnt + 9'h001;
		end
		act_rise = s_r.sys_ctrl[mag_extremes_pkg::ACTIVE_BIT]
			&& !s_r.active_d;
		s_nxt.active_d = s_r.sys_ctrl[mag_extremes_pkg::ACTIVE_BIT];

		// Degauss sequence; periodic and active triggers during a run are dropped, a one-shot set then waits for idle
		case (s_r.dg_st)
			mag_extremes_pkg::DG_IDLE: begin
				if (dg_due || act_rise ||
					s_r.ctrl_one[mag_extremes_pkg::DG_ONESHOT_BIT]) begin
					s_nxt.dg_start = 1'b1;
					s_nxt.dg_count = s_r.dg_count + 16'h0001;
					s_nxt.dg_own_oneshot =
						s_r.ctrl_one[mag_extremes_pkg::DG_ONESHOT_BIT];
					s_nxt.dg_st = mag_extremes_pkg::DG_BUSY;
				end
			end
			mag_extremes_pkg::DG_BUSY: begin
				if (DEGAUSS_DONE) begin
					if (s_r.dg_own_oneshot) begin
						s_nxt.ctrl_one[mag_extremes_pkg::DG_ONESHOT_BIT] =
							1'b0;
					end
					s_nxt.dg_own_oneshot = 1'b0;
					s_nxt.dg_st = mag_extremes_pkg::DG_IDLE;
				end
			end
			default: begin
				s_nxt.dg_st = mag_extremes_pkg::DG_IDLE;
			end
		endcase

		// APB: one wait state, read data captured before the answer
		access = PSEL && PENABLE;
		idx = reg_index(PADDR);
		case (idx)
			4'h0: rd = {24'h000000, s_r.ctrl_two};
			4'h1: rd = {24'h000000, s_r.ctrl_one};
			4'h2: rd = {30'h00000000, s_r.sys_ctrl};
			4'h3: rd = {s_r.dg_count, 12'h000, s_r.thr_stop,
				s_r.dg_st == mag_extremes_pkg::DG_BUSY,
				s_r.clr_st == mag_extremes_pkg::CLR_LOAD, track_en};
			4'h5: rd = {ax_max[0], ax_min[0]};
			4'h6: rd = {ax_max[1], ax_min[1]};
			4'h7: rd = {ax_max[2], ax_min[2]};
			4'h8: rd = {16'h0000, ax_off[0]};
			4'h9: rd = {16'h0000, ax_off[1]};
			4'hA: rd = {16'h0000, ax_off[2]};
			default: rd = 32'h00000000;
		endcase
		if (access && !s_r.pready) begin
			s_nxt.pready = 1'b1;
			s_nxt.pslverr = idx == 4'hF;
			s_nxt.prdata = PWRITE ? 32'h00000000 : rd;
		end else begin
			s_nxt.pready = 1'b0;
			s_nxt.pslverr = 1'b0;
		end
		// Writes land on the completing edge; they override the
		// hardware clears above, so a fresh 1 is never lost
		if (access && s_r.pready && PWRITE && PSTRB[0]) begin
			case (idx)
				4'h0: begin
					s_nxt.ctrl_two = PWDATA[7:0];
					s_nxt.thr_stop = 1'b0;
				end
				4'h1: s_nxt.ctrl_one = PWDATA[7:0];
				4'h2: s_nxt.sys_ctrl = PWDATA[1:0];
				default: begin
				end
			endcase
		end
		// Threshold stop set after the write: the event wins
		if (THRESHOLD_EVENT
			&& s_r.ctrl_two[mag_extremes_pkg::STOP_THS_BIT]) begin
			s_nxt.thr_stop = 1'b1;
		end
	end

	// ***************************************************************
	// State register
	// ***************************************************************
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			s_r <= '0;
			s_r.ctrl_two <= mag_extremes_pkg::RST_MAG_CONTROL_TWO;
			s_r.ctrl_one <= mag_extremes_pkg::RST_MAG_CONTROL_ONE;
			s_r.sys_ctrl <= mag_extremes_pkg::RST_SYSTEM_CONTROL_ONE;
			s_r.clr_st <= mag_extremes_pkg::CLR_IDLE;
			s_r.dg_st <= mag_extremes_pkg::DG_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ***************************************************************
	// Outputs
	// ***************************************************************
	assign PRDATA = s_r.prdata;
	assign PREADY = s_r.pready;
	assign PSLVERR = s_r.pslverr;
	assign DEGAUSS_START = s_r.dg_start;
	assign MAG_OFFSET = '{x: ax_off[0], y: ax_off[1], z: ax_off[2]};

endmodule : mag_extremes_degauss_ctrl

`default_nettype wire

/* test/mag_extremes_degauss_ctrl_properties.sv */
// Checker of the extremes and degauss block, bound to its top ports.
// Assumes one CLK domain; control bits are shadowed from APB writes.
`default_nettype none

module mag_extremes_degauss_ctrl_properties (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic PREADY,
	input wire logic ODR_START,
	input wire logic DEGAUSS_START,
	input wire logic DEGAUSS_DONE,
	input wire logic BURST_LOAD,
	input wire logic BURST_ADVANCE,
	input wire logic [7:0] BURST_ADDR
);
	timeunit 1ns;
	timeprecision 100ps;

	// ****************
	// Shadow state
	// ****************
	logic wr; // Write completing now
	logic wrap_r, fast_r, act_r; // Wrap, fast read, active
	logic busy_r; // Degauss in flight
	logic os_r; // One-shot pending; cleared by any done
	logic [1:0] ivl_r, sel_r; // Interval and sensor select
	logic [8:0] cnt_r; // ODR starts since reset
	logic hit; // Periodic degauss due at this start

	assign wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
	assign hit = ivl_r == 2'h0 || (ivl_r == 2'h1 && cnt_r[3:0] == 4'hF)
		|| (ivl_r == 2'h2 && cnt_r == 9'h1FF);

	// Follow writes so the checker needs no register reads
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			{wrap_r, fast_r, act_r, busy_r, os_r} <= 5'h00;
			{ivl_r, sel_r} <= 4'h0;
			cnt_r <= 9'h000;
		end else begin
			if (wr && PADDR == 12'h05C) begin
				wrap_r <= PWDATA[5];
				ivl_r <= PWDATA[1:0];
			end
			if (wr && PADDR == 12'h064) begin
				{fast_r, act_r} <= PWDATA[1:0];
			end
			if (wr && PADDR == 12'h060) begin
				sel_r <= PWDATA[1:0];
			end
			if (wr && PADDR == 12'h060 && PWDATA[6]) begin
				os_r <= 1'b1;
			end else if (DEGAUSS_DONE) begin
				os_r <= 1'b0;
			end
			if (DEGAUSS_START) begin
				busy_r <= 1'b1;
			end else if (DEGAUSS_DONE) begin
				busy_r <= 1'b0;
			end
			if (ODR_START) begin
				cnt_r <= cnt_r + 9'h001;
			end
		end
	end

	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	// Pointer advance from a given byte
	sequence s_adv(logic [7:0] a);
		BURST_ADVANCE && !BURST_LOAD && BURST_ADDR == a;
	endsequence
	// Idle-engine write setting one bit
	sequence s_wr_bit(logic [11:0] a, int b);
		wr && PADDR == a && PWDATA[b] && !busy_r && !DEGAUSS_START;
	endsequence
	sequence s_dg_soon;
		##[1:3] DEGAUSS_START;
	endsequence

	AST_WRAP_NORMAL: assert property (s_adv(8'h06) ##0 (wrap_r && !fast_r)
		|=> BURST_ADDR == 8'h33) else $error("No wrap after Z low");
	AST_WRAP_FAST: assert property (s_adv(8'h05) ##0 (wrap_r && fast_r)
		|=> BURST_ADDR == 8'h33) else $error("No wrap after Z high");
	AST_NO_WRAP: assert property (BURST_ADVANCE && !BURST_LOAD && !wrap_r
		|=> BURST_ADDR == $past(BURST_ADDR) + 8'h01)
		else $error("Pointer not sequential");
	AST_DG_PERIODIC: assert property (ODR_START && hit && sel_r != 2'h3
		&& !busy_r && !DEGAUSS_START |=> DEGAUSS_START)
		else $error("Periodic degauss missing");
	AST_DG_QUIET: assert property (ODR_START && !hit && !os_r && !busy_r
		&& !DEGAUSS_START && !PSEL && !$past(PSEL) && !$past(PSEL, 2)
		&& !$past(PSEL, 3) |=> !DEGAUSS_START)
		else $error("Degauss with no cause");
	AST_DG_ACTIVE: assert property (s_wr_bit(12'h064, 0) ##0 !act_r
		|-> s_dg_soon) else $error("No degauss on going active");
	AST_DG_ONESHOT: assert property (s_wr_bit(12'h060, 6)
		|-> s_dg_soon) else $error("No one-shot degauss");
	AST_DG_PULSE: assert property (DEGAUSS_START |=> !DEGAUSS_START)
		else $error("Degauss request too long");
	AST_APB_WAIT: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
		else $error("Ready not after one wait");
endmodule : mag_extremes_degauss_ctrl_properties

bind mag_extremes_degauss_ctrl mag_extremes_degauss_ctrl_properties i_props (
	.CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PREADY,
	.ODR_START, .DEGAUSS_START, .DEGAUSS_DONE, .BURST_LOAD, .BURST_ADVANCE,
	.BURST_ADDR);

`default_nettype wire

/* test/mag_degauss_model.sv */
// Model of the sensor degauss engine behind the block.
// Assumes lat is at least one; done pulses lat plus one cycles after start.
`default_nettype none

module mag_degauss_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic [7:0] lat,
	output logic done,
	output logic [15:0] runs
);
	timeunit 1ns;
	timeprecision 100ps;

	// ****************
	// Engine
	// ****************
	logic [7:0] cnt; // Cycles left in this run

	// Count down; a slow lat shows the busy window to software
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 8'h00;
			done <= 1'b0;
			runs <= 16'h0000;
		end else begin
			done <= cnt == 8'h01;
			if (start) begin
				cnt <= lat;
				runs <= runs + 16'h0001;
			end else if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule : mag_degauss_model

`default_nettype wire

/* test/mag_extremes_degauss_ctrl_test.sv */
// Self-checking bench of the extremes and degauss block over APB.
// Assumes the degauss model answers every start pulse.
`default_nettype none

module mag_extremes_degauss_ctrl_test;
	timeunit 1ns;
	timeprecision 100ps;

	// ****************
	// Signals
	// ****************
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic odr_start, odr_end, mvalid, thr, dg_done, dg_start, bload, badv;
	logic [7:0] bladdr, baddr, lat;
	logic [15:0] runs, r0;
	mag_extremes_pkg::mag_sample_s msample, moff;
	int n_fail, num_checks;

	mag_extremes_degauss_ctrl i_mag_extremes_degauss_ctrl (
		.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.ODR_START(odr_start), .ODR_END(odr_end), .MAG_SAMPLE_VALID(mvalid),
		.MAG_SAMPLE(msample), .THRESHOLD_EVENT(thr), .DEGAUSS_DONE(dg_done),
		.DEGAUSS_START(dg_start), .MAG_OFFSET(moff), .BURST_LOAD(bload),
		.BURST_LOAD_ADDR(bladdr), .BURST_ADVANCE(badv), .BURST_ADDR(baddr));

	mag_degauss_model i_mag_degauss_model (.clk(clk), .resetn(resetn),
		.start(dg_start), .lat(lat), .done(dg_done), .runs(runs));

	// ****************
	// Tasks
	// ****************
	task automatic stop_test();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// One APB transfer; holds everything until ready is sampled
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] m, e);
		apb(1'b0, a, 32'h00000000);
		chk(rdata & m, e);
	endtask : rd

	// Full ODR cycles: start, one sample, end
	task automatic odr(input int n);
		repeat (n) begin
			@(posedge clk);
			odr_start <= 1'b1;
			@(posedge clk);
			odr_start <= 1'b0;
			mvalid <= 1'b1;
			@(posedge clk);
			mvalid <= 1'b0;
			odr_end <= 1'b1;
			@(posedge clk);
			odr_end <= 1'b0;
		end
	endtask : odr

	task automatic thr_pulse();
		@(posedge clk);
		thr <= 1'b1;
		@(posedge clk);
		thr <= 1'b0;
	endtask : thr_pulse

	// Set interval, run cycles, count degauss runs
	task automatic dg(input logic [31:0] v, input int n, e);
		wr(12'h05C, v);
		r0 = runs;
		odr(n);
		repeat (30) @(posedge clk);
		chk(runs - r0, e);
	endtask : dg

	// Load pointer, advance twice, check each step
	task automatic bt(input logic w, f, input logic [7:0] s, e1, e2);
		wr(12'h05C, {26'h0, w, 5'h03});
		wr(12'h064, {30'h0, f, 1'b0});
		@(posedge clk);
		bload <= 1'b1;
		bladdr <= s;
		@(posedge clk);
		bload <= 1'b0;
		badv <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		badv <= 1'b0;
		chk({24'h0, baddr}, {24'h0, e1});
		@(posedge clk);
		chk({24'h0, baddr}, {24'h0, e2});
	endtask : bt

	// ****************
	// Clock, watchdog and sequence
	// ****************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Ceiling well above the roughly 2700 cycles needed
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		stop_test();
	end

	initial begin
		{resetn, psel, penable, pwrite, odr_start, odr_end} = 6'h00;
		{mvalid, thr, bload, badv} = 4'h0;
		{paddr, pwdata, bladdr, msample} = '0;
		// Short run: engine idle again before the next ODR start
		lat = 8'h01;
		n_fail = 0;
		num_checks = 0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		rd(12'h05C, 32'hFFFFFFFF, 32'h00000000);
		wr(12'h05C, 32'h000000C3);
		rd(12'h05C, 32'hFFFFFFFF, 32'h000000C3);
		msample <= {16'h0010, 16'hFFF0, 16'h0100};
		odr(1);
		msample <= {16'hFF00, 16'h0020, 16'h0100};
		odr(1);
		rd(12'h070, 32'hFFFFFFFF, 32'h0010FF00);
		rd(12'h074, 32'hFFFFFFFF, 32'h0020FFF0);
		rd(12'h078, 32'hFFFFFFFF, 32'h01000100);
		wr(12'h060, 32'h00000080);
		odr(2);
		rd(12'h080, 32'hFFFFFFFF, 32'h0000FF88);
		chk({16'h0, moff.y}, 32'h00000008);
		wr(12'h05C, 32'h000000D3);
		msample <= {16'h7000, 16'h0020, 16'h0100};
		odr(1);
		rd(12'h070, 32'hFFFFFFFF, 32'h0010FF00);
		wr(12'h05C, 32'h000000C3);
		odr(1);
		rd(12'h070, 32'hFFFFFFFF, 32'h7000FF00);
		wr(12'h05C, 32'h000000CB);
		thr_pulse();
		msample <= {16'h7100, 16'h0020, 16'h0100};
		odr(1);
		rd(12'h070, 32'hFFFFFFFF, 32'h7000FF00);
		rd(12'h068, 32'h00000008, 32'h00000008);
		wr(12'h05C, 32'h000000C3);
		thr_pulse();
		odr(1);
		rd(12'h070, 32'hFFFFFFFF, 32'h7100FF00);
		wr(12'h05C, 32'h000000C7);
		repeat (4) @(posedge clk);
		rd(12'h05C, 32'hFFFFFFFF, 32'h000000C3);
		for (int i = 0; i < 3; i++) begin
			rd(12'h070 + 12'(4 * i), 32'hFFFFFFFF, 32'h80007FFF);
		end
		bt(1'b1, 1'b0, 8'h05, 8'h06, 8'h33);
		bt(1'b1, 1'b1, 8'h04, 8'h05, 8'h33);
		bt(1'b0, 1'b0, 8'h05, 8'h06, 8'h07);
		bt(1'b0, 1'b1, 8'h05, 8'h06, 8'h07);
		bt(1'b1, 1'b1, 8'h05, 8'h33, 8'h34);
		dg(32'h00000000, 3, 3);
		dg(32'h00000001, 32, 2);
		dg(32'h00000002, 512, 1);
		dg(32'h00000003, 5, 0);
		r0 = runs;
		wr(12'h064, 32'h00000001);
		repeat (10) @(posedge clk);
		wr(12'h064, 32'h00000001);
		repeat (10) @(posedge clk);
		chk(runs - r0, 32'h00000001);
		wr(12'h064, 32'h00000000);
		lat <= 8'h14;
		r0 = runs;
		wr(12'h060, 32'h000000C0);
		rd(12'h060, 32'h00000040, 32'h00000040);
		repeat (30) @(posedge clk);
		rd(12'h060, 32'h00000040, 32'h00000000);
		chk(runs - r0, 32'h00000001);
		lat <= 8'h01;
		rd(12'h0FC, 32'hFFFFFFFF, 32'h00000000);
		chk({31'h0, rerr}, 32'h00000001);
		wr(12'h060, 32'h00000083);
		dg(32'h00000000, 4, 2);
		stop_test();
	end
endmodule : mag_extremes_degauss_ctrl_test

`default_nettype wire
